/* verilog/ccf_flags.sv */
// State flag word of the 16-bit core with its register access port
`timescale 1ns/1ps
// **********************************************************************
// **********************************************************************
module ccf_flags
  import ccf_pkg::*;
#(
  parameter int DW = CCF_DATA_W
) (
  input  wire logic          CLK,
  input  wire logic          RESET,
  input  wire logic [3:0]    WB_ADR_I,
  input  wire logic [31:0]   WB_DAT_I,
  input  wire logic [3:0]    WB_SEL_I,
  input  wire logic          WB_WE_I,
  input  wire logic          WB_CYC_I,
  input  wire logic          WB_STB_I,
  output logic      [31:0]   WB_DAT_O,
  output logic               WB_ACK_O,
  input  wire logic          ALU_VALID,
  input  wire logic [DW-1:0] ALU_RESULT,
  input  wire logic          ALU_CARRY,
  input  wire logic          ALU_OVFL,
  input  wire logic          UPD_CARRY,
  input  wire logic          UPD_ZERO,
  input  wire logic          UPD_SIGN,
  input  wire logic          UPD_OVFL,
  output logic [CCF_WORD_W-1:0] PROCESSOR_STATE_WORD,
  output logic               BANK_SEL
);
  // **********************************************************************
  // Bus slave
  // **********************************************************************
  ccf_bus_t                state_q, state_d;
  logic [31:0]             rdat_q, rdat_d;
  logic [CCF_WORD_W-1:0]   psw_q, psw_d;
  logic [DW-1:0]           res_q, res_d;
  logic                    ack_q, ack_d;
  logic                    req;
  logic                    wr_psw;

  assign req    = WB_CYC_I && WB_STB_I && (state_q == CCF_BUS_IDLE);
  assign wr_psw = req && WB_WE_I && WB_SEL_I[0] && WB_SEL_I[1]
                  && (WB_ADR_I == CCF_ADDR_PSW);

  always_comb begin
    state_d = state_q;
    ack_d   = 1'b0;
    rdat_d  = 32'h0000_0000;
    case (state_q)
      CCF_BUS_IDLE: begin
        if (req) begin
          state_d = CCF_BUS_ACK;
          ack_d   = 1'b1;
          case (WB_ADR_I)
            CCF_ADDR_PSW:     rdat_d = 32'(psw_q);
            CCF_ADDR_ALU_RES: rdat_d = 32'(res_q);
            CCF_ADDR_BANK:    rdat_d = 32'(psw_q[CCF_BIT_BANK]);
            default:          rdat_d = 32'h0000_0000;
          endcase
        end
      end
      // One ack then idle, so a strobe still held is not answered twice
      CCF_BUS_ACK: begin
        state_d = CCF_BUS_IDLE;
      end
      default: begin
        state_d = CCF_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_q <= CCF_BUS_IDLE;
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
    end
  end

  // **********************************************************************
  // Flag update
  // **********************************************************************
  always_comb begin
    psw_d = psw_q;
    res_d = res_q;
    if (wr_psw) begin
      // Debug bit is stored as written; software is expected to keep it 0
      psw_d = WB_DAT_I[CCF_WORD_W-1:0] & CCF_WR_MASK;
    end
    // ALU wins over a same-cycle bus write on the flags it updates, so no result is lost
    if (ALU_VALID) begin
      res_d = ALU_RESULT;
      if (UPD_CARRY) psw_d[CCF_BIT_CARRY] = ALU_CARRY;
      if (UPD_ZERO)  psw_d[CCF_BIT_ZERO]  = (ALU_RESULT == '0);
      if (UPD_SIGN)  psw_d[CCF_BIT_SIGN]  = ALU_RESULT[DW-1];
      if (UPD_OVFL)  psw_d[CCF_BIT_OVFL]  = ALU_OVFL;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      psw_q <= CCF_PSW_RESET;
      res_q <= '0;
    end else begin
      psw_q <= psw_d;
      res_q <= res_d;
    end
  end

  assign WB_DAT_O             = rdat_q;
  // Ack has its own flop so the output carries no decode glitch
  assign WB_ACK_O             = ack_q;
  assign PROCESSOR_STATE_WORD = psw_q;
  assign BANK_SEL             = psw_q[CCF_BIT_BANK];

  // **********************************************************************
  // Assertions
  // **********************************************************************
  property p_zero;
    @(posedge CLK) disable iff (RESET)
      (ALU_VALID && UPD_ZERO) |=>
        psw_q[CCF_BIT_ZERO] == ($past(ALU_RESULT) == '0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_sign;
    @(posedge CLK) disable iff (RESET)
      (ALU_VALID && UPD_SIGN) |=>
        psw_q[CCF_BIT_SIGN] == $past(ALU_RESULT[DW-1]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");

  property p_carry;
    @(posedge CLK) disable iff (RESET)
      (ALU_VALID && UPD_CARRY) |=> psw_q[CCF_BIT_CARRY] == $past(ALU_CARRY);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");

  property p_ovfl;
    @(posedge CLK) disable iff (RESET)
      (ALU_VALID && UPD_OVFL) |=> psw_q[CCF_BIT_OVFL] == $past(ALU_OVFL);
  endproperty
  a_ovfl: assert property (p_ovfl) else $error("overflow flag wrong");

  property p_hold;
    @(posedge CLK) disable iff (RESET)
      (!ALU_VALID && !wr_psw) |=> $stable(psw_q);
  endproperty
  a_hold: assert property (p_hold) else $error("flags changed idly");

  property p_bank;
    @(posedge CLK) disable iff (RESET)
      (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O &&
       WB_ADR_I == CCF_ADDR_PSW && WB_SEL_I[1:0] == 2'b11) |=>
        BANK_SEL == $past(WB_DAT_I[CCF_BIT_BANK]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select mismatch");

  property p_width;
    @(posedge CLK) disable iff (RESET)
      WB_ACK_O && $past(WB_ADR_I) == CCF_ADDR_PSW |->
        WB_DAT_O[31:CCF_WORD_W] == '0;
  endproperty
  a_width: assert property (p_width) else $error("high bits not zero");

  property p_ack;
    @(posedge CLK) disable iff (RESET)
      req |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");

  property p_rsvd;
    @(posedge CLK) disable iff (RESET)
      PROCESSOR_STATE_WORD[CCF_WORD_W-1:CCF_BIT_OVFL+1] == '0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("unused bits set");

  // No disable here, so the reset value itself is checked
  property p_reset;
    @(posedge CLK)
      RESET |=> (PROCESSOR_STATE_WORD == CCF_PSW_RESET) && !WB_ACK_O;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  // Refused writes must not disturb the word
  property p_refuse;
    @(posedge CLK) disable iff (RESET)
      (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && !ALU_VALID &&
       (WB_ADR_I != CCF_ADDR_PSW || WB_SEL_I[1:0] != 2'b11)) |=>
        $stable(PROCESSOR_STATE_WORD);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused write landed");

  property p_rdpsw;
    @(posedge CLK) disable iff (RESET)
      (WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O &&
       WB_ADR_I == CCF_ADDR_PSW) |=>
        WB_ACK_O && WB_DAT_O == 32'($past(PROCESSOR_STATE_WORD));
  endproperty
  a_rdpsw: assert property (p_rdpsw) else $error("word readback wrong");

  property p_rdres;
    @(posedge CLK) disable iff (RESET)
      (WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O &&
       WB_ADR_I == CCF_ADDR_ALU_RES) |=>
        WB_DAT_O == 32'($past(res_q));
  endproperty
  a_rdres: assert property (p_rdres) else $error("result readback wrong");

  property p_alures;
    @(posedge CLK) disable iff (RESET)
      ALU_VALID |=> res_q == $past(ALU_RESULT);
  endproperty
  a_alures: assert property (p_alures) else $error("result not kept");
endmodule

/* verilog/ccf_pkg.sv */
// Package: register map, field layout and reset values of the state flag block
package ccf_pkg;
  localparam int          CCF_WORD_W       = 11;
  localparam int          CCF_DATA_W       = 16;
  localparam logic [3:0]  CCF_ADDR_PSW     = 4'h0;
  localparam logic [3:0]  CCF_ADDR_ALU_RES = 4'h4;
  localparam logic [3:0]  CCF_ADDR_BANK    = 4'h8;
  localparam int          CCF_BIT_CARRY    = 0;
  localparam int          CCF_BIT_DEBUG    = 1;
  localparam int          CCF_BIT_ZERO     = 2;
  localparam int          CCF_BIT_SIGN     = 3;
  localparam int          CCF_BIT_BANK     = 4;
  localparam int          CCF_BIT_OVFL     = 5;
  localparam logic [10:0] CCF_WR_MASK      = 11'h03f;
  localparam logic [10:0] CCF_PSW_RESET    = 11'h000;
  localparam logic [3:0]  CCF_OP_NONE      = 4'h0;

  typedef enum logic [1:0] {
    CCF_BUS_IDLE = 2'b00,
    CCF_BUS_ACK  = 2'b01
  } ccf_bus_t;
endpackage

/* tb/testbench.sv */
// Self-checking bench for the state flag block
`timescale 1ns/1ps
module testbench;
  import ccf_pkg::*;
  // ****************************************
  // Signals and design
  // ****************************************
  logic                  clk = 0, rst = 1, we = 0, cyc = 0, stb = 0;
  logic                  av = 0, ac = 0, ao = 0, ack, bank;
  logic [3:0]            adr = 4'h0, upd = 4'h0, sel = 4'hf;
  logic [31:0]           wd = 32'h0, rd, rdat;
  logic [15:0]           res = 16'h0;
  logic [CCF_WORD_W-1:0] psw;
  int                    fail_count = 0, checks = 0;
  ccf_flags i_ccf_flags (.CLK(clk), .RESET(rst), .WB_ADR_I(adr),
    .WB_DAT_I(wd), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_DAT_O(rd), .WB_ACK_O(ack), .ALU_VALID(av),
    .ALU_RESULT(res), .ALU_CARRY(ac), .ALU_OVFL(ao),
    .UPD_CARRY(upd[0]), .UPD_ZERO(upd[1]), .UPD_SIGN(upd[2]),
    .UPD_OVFL(upd[3]), .PROCESSOR_STATE_WORD(psw), .BANK_SEL(bank));
  initial forever #2.5 clk = ~clk;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Ack and read data are taken at the rising edge that samples ack high
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, s};
    do @(posedge clk); while (ack !== 1'b1);
    rdat = rd;
    {cyc, stb, we} <= 3'b000;
    @(posedge clk);
  endtask
  task automatic alu(input logic [15:0] r, input logic c, input logic o,
                     input logic [3:0] u);
    @(posedge clk);
    {av, res, ac, ao, upd} <= {1'b1, r, c, o, u};
    @(posedge clk);
    av <= 1'b0;
    @(negedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, CCF_ADDR_PSW, 32'h0, 4'hf);
    chk(rdat, 32'h0);
    chk(32'(bank), 32'h0);
    wb(1'b0, 4'hc, 32'h0, 4'hf);
    chk(rdat, 32'h0);
    $display("reset and map test done");
    wb(1'b1, CCF_ADDR_PSW, 32'h7fd, 4'hf);
    wb(1'b0, CCF_ADDR_PSW, 32'h0, 4'hf);
    chk(rdat, 32'h03d);
    chk(32'(bank), 32'h1);
    wb(1'b0, CCF_ADDR_BANK, 32'h0, 4'hf);
    chk(rdat, 32'h1);
    wb(1'b1, CCF_ADDR_PSW, 32'h0, 4'h1);
    wb(1'b1, 4'hc, 32'h0, 4'hf);
    chk(32'(psw), 32'h03d);
    wb(1'b1, CCF_ADDR_PSW, 32'h0, 4'hf);
    chk(32'(bank), 32'h0);
    $display("bank test done");
    alu(16'h0000, 1'b1, 1'b0, 4'hf);
    chk(32'(psw), 32'h005);
    alu(16'h8000, 1'b0, 1'b1, 4'hf);
    chk(32'(psw), 32'h028);
    alu(16'h0001, 1'b1, 1'b0, 4'h0);
    chk(32'(psw), 32'h028);
    alu(16'h0001, 1'b1, 1'b0, 4'h1);
    chk(32'(psw), 32'h029);
    wb(1'b0, CCF_ADDR_ALU_RES, 32'h0, 4'hf);
    chk(rdat, 32'h0000_0001);
    fork
      wb(1'b1, CCF_ADDR_PSW, 32'h010, 4'hf);
      alu(16'h0000, 1'b0, 1'b0, 4'h2);
    join
    chk(32'(psw), 32'h014);
    $display("flag update test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, CCF_ADDR_PSW, 32'h0, 4'hf);
    chk(rdat, 32'h0);
    chk(32'(bank), 32'h0);
    $display("mid-run reset test done");
    end_of_test;
  end
  // Whole run takes well under 200 cycles
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    end_of_test;
  end
endmodule
